// file: verilog/four_mode_serial_port.v
`include "serial_port_defs.vh"

module serial_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_i,      // Clock
  input  wire             reset_n_i,  // Async reset, low
  input  wire             in_valid_i, // Push request
  output wire             in_ready_o, // Space available
  input  wire [WIDTH-1:0] in_data_i,  // Push data
  output wire             out_valid_o,// Data available
  input  wire             out_ready_i,// Pop request
  output wire [WIDTH-1:0] out_data_o  // Head data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers wrap; depth must be a power of two
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // serial_fifo

module four_mode_serial_port #(
  parameter TXQ_DEPTH = 32,
  parameter TXQ_AW    = 5
) (
  input  wire       core_clk_i,   // 50 MHz oscillator clock
  input  wire       reset_n_i,    // Async reset, active low
  input  wire [7:0] sfr_addr_i,   // Register address
  input  wire       sfr_wr_i,     // Write strobe
  input  wire       sfr_rd_i,     // Read strobe
  input  wire [7:0] sfr_wdata_i,  // Write data
  output reg  [7:0] sfr_rdata_o,  // Read data, next cycle
  input  wire       t1_ovf_i,     // Timer 1 overflow pulse
  input  wire       rxd_i,        // Receive pin level
  output reg        rxd_o,        // Receive pin drive (mode 0)
  output reg        rxd_oe_o,     // Receive pin enable
  output reg        txd_o,        // Transmit pin
  output reg        irq_o,        // Serial interrupt request
  output reg        txq_ready_o   // Transmit queue has room
);
  reg  [7:0] ctl_q;
  reg  [7:0] pwr_q;
  reg  [7:0] rx_buf_q;
  reg        rxd_meta_q;
  reg        rxd_sync_q;
  reg        rxd_prev_q;
  reg  [1:0] pre_q;
  reg        ovf_half_q;
  reg  [3:0] tx_phase_q;
  reg  [3:0] rx_phase_q;
  reg [10:0] tx_shift_q;
  reg  [3:0] tx_left_q;
  reg        tx_busy_q;
  localparam RX_IDLE  = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA  = 3'b100;
  reg  [2:0] rx_state_q;
  reg  [8:0] rx_shift_q;
  reg  [3:0] rx_got_q;
  reg        m0_busy_q;
  reg        m0_is_rx_q;
  reg  [3:0] m0_clk_q;
  reg  [3:0] m0_left_q;
  reg  [7:0] m0_shift_q;
  reg        tx_done_set;
  reg        rx_done_set;
  reg        rx_load;
  reg  [7:0] rx_load_data;
  reg        rx_load_ninth;
  reg        tick;

  wire [1:0] mode       = {ctl_q[`CTL_MODE_HI], ctl_q[`CTL_MODE_LO]};
  wire       dbl        = pwr_q[`PWR_BAUD_DOUBLE];
  wire       wr_ctl     = sfr_wr_i && (sfr_addr_i == `SFR_ADDR_CONTROL);
  wire       wr_buf     = sfr_wr_i && (sfr_addr_i == `SFR_ADDR_BUFFER);
  wire       wr_pwr     = sfr_wr_i && (sfr_addr_i == `SFR_ADDR_POWER);
  wire       q_valid;
  wire [7:0] q_data;
  wire       q_ready;
  // Async frames start on a tick, else the start bit comes out short by up to one tick
  wire       q_pop      = q_valid && !tx_busy_q && !m0_busy_q && (tick || (mode == `MODE_SHIFT));
  wire       tick_end   = tick && (tx_phase_q == `TICKS_PER_BIT);
  wire       rx_sample  = tick && (rx_phase_q == `TICK_MID_SAMPLE);
  wire       m0_rx_go   = (mode == `MODE_SHIFT) && !m0_busy_q && !q_valid &&
                          ctl_q[`CTL_RX_ENABLE] && !ctl_q[`CTL_RX_DONE];

  // Buffer writes queue for the transmitter; a full queue drops the write
  serial_fifo #(
    .WIDTH (8),
    .DEPTH (TXQ_DEPTH),
    .AW    (TXQ_AW)
  ) u_txq (
    .clk_i       (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (wr_buf),
    .in_ready_o  (q_ready),
    .in_data_i   (sfr_wdata_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  // Sixteen ticks per bit in the asynchronous modes
  always @* begin
    case (mode)
      `MODE_FIXED9: tick = (pre_q == 2'h0);
      `MODE_ASYNC8,
      `MODE_VAR9:   tick = t1_ovf_i && (dbl || ovf_half_q);
      default:      tick = 1'b0;
    endcase
  end

  // Prescaler: 4 clocks per tick gives osc/64, 2 gives osc/32
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q      <= 2'h0;
      ovf_half_q <= 1'b0;
    end else begin
      if (pre_q == 2'h0) begin
        pre_q <= dbl ? `FIXED_TICK_FAST : `FIXED_TICK_SLOW;
      end else begin
        pre_q <= pre_q - 2'h1;
      end
      if (t1_ovf_i) begin
        ovf_half_q <= ~ovf_half_q; // Halves overflow rate when not doubled
      end
    end
  end

  // Pin synchroniser; the second stage feeds logic, the third only the falling-edge detector
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_i;
      rxd_sync_q <= rxd_meta_q;
      rxd_prev_q <= rxd_sync_q;
    end
  end

  // Asynchronous transmitter, independent of the receiver
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_phase_q <= 4'h0;
      tx_shift_q <= 11'h7ff;
      tx_left_q  <= 4'h0;
      tx_busy_q  <= 1'b0;
    end else begin
      if (tick) begin
        tx_phase_q <= tx_phase_q + 4'h1;
      end
      if (q_pop && (mode != `MODE_SHIFT)) begin
        // Stop, ninth (or stop again in mode 1), data LSB first, start
        tx_shift_q <= {1'b1, (mode == `MODE_ASYNC8) ? 1'b1 : ctl_q[`CTL_TX_NINTH],
                       q_data, 1'b0};
        tx_left_q  <= (mode == `MODE_ASYNC8) ? `FRAME_BITS_8 : `FRAME_BITS_9;
        tx_busy_q  <= 1'b1;
        tx_phase_q <= 4'h0;
      end else if (tx_busy_q && tick_end) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_left_q  <= tx_left_q - 4'h1;
        if (tx_left_q == 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // Asynchronous receiver state machine
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_got_q   <= 4'h0;
    end else begin
      if (tick) begin
        rx_phase_q <= rx_phase_q + 4'h1;
      end
      case (rx_state_q)
        RX_IDLE: begin
          // Falling edge realigns the bit timing to the start bit
          if ((mode != `MODE_SHIFT) && ctl_q[`CTL_RX_ENABLE] &&
              rxd_prev_q && !rxd_sync_q) begin
            rx_state_q <= RX_START;
            rx_phase_q <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_got_q   <= 4'h0;
            rx_state_q <= rxd_sync_q ? RX_IDLE : RX_DATA; // Glitch rejected
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            // Nine samples: data then stop (mode 1) or ninth (modes 2/3)
            rx_shift_q <= {rxd_sync_q, rx_shift_q[8:1]};
            rx_got_q   <= rx_got_q + 4'h1;
            if (rx_got_q == (`RX_SAMPLE_BITS - 4'h1)) begin
              rx_state_q <= RX_IDLE; // Mode 2/3 stop bit never sampled
            end
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
      if (mode == `MODE_SHIFT) begin
        rx_state_q <= RX_IDLE;
      end
    end
  end

  // Mode 0 engine; shares both pins, so only one direction at a time
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m0_busy_q  <= 1'b0;
      m0_is_rx_q <= 1'b0;
      m0_clk_q   <= 4'h0;
      m0_left_q  <= 4'h0;
      m0_shift_q <= 8'h00;
    end else begin
      if (q_pop && (mode == `MODE_SHIFT)) begin
        m0_busy_q  <= 1'b1;
        m0_is_rx_q <= 1'b0;
        m0_shift_q <= q_data;
        m0_clk_q   <= 4'h0;
        m0_left_q  <= `SHIFT_DATA_BITS;
      end else if (m0_rx_go) begin
        m0_busy_q  <= 1'b1;
        m0_is_rx_q <= 1'b1;
        m0_clk_q   <= 4'h0;
        m0_left_q  <= `SHIFT_DATA_BITS;
      end else if (m0_busy_q) begin
        if (m0_clk_q == (`SHIFT_BIT_CLKS - 4'h1)) begin
          m0_clk_q   <= 4'h0;
          m0_left_q  <= m0_left_q - 4'h1;
          if (!m0_is_rx_q) begin
            m0_shift_q <= {1'b0, m0_shift_q[7:1]};
          end
          if (m0_left_q == 4'h1) begin
            m0_busy_q <= 1'b0;
          end
        end else begin
          m0_clk_q <= m0_clk_q + 4'h1;
        end
        // Receive samples at the rising edge of the shift clock
        if (m0_is_rx_q && (m0_clk_q == `SHIFT_CLK_HALF)) begin
          m0_shift_q <= {rxd_sync_q, m0_shift_q[7:1]};
        end
      end
      if (mode != `MODE_SHIFT) begin
        m0_busy_q <= 1'b0;
      end
    end
  end

  // Completion events for both directions
  always @* begin
    tx_done_set   = 1'b0;
    rx_done_set   = 1'b0;
    rx_load       = 1'b0;
    rx_load_data  = rx_shift_q[8:1];
    rx_load_ninth = rxd_sync_q;
    if (tx_busy_q && tick_end && (tx_left_q == 4'h1)) begin
      tx_done_set = 1'b1;
    end
    if (m0_busy_q && (m0_clk_q == (`SHIFT_BIT_CLKS - 4'h1)) && (m0_left_q == 4'h1)) begin
      if (m0_is_rx_q) begin
        rx_load      = 1'b1;
        rx_load_data = m0_shift_q;
        rx_done_set  = 1'b1;
      end else begin
        tx_done_set  = 1'b1;
      end
    end
    if ((rx_state_q == RX_DATA) && rx_sample && (rx_got_q == (`RX_SAMPLE_BITS - 4'h1))) begin
      // Unread buffer keeps the older byte; the new one is lost
      if (!ctl_q[`CTL_RX_DONE] &&
          (!ctl_q[`CTL_MULTIPROC] || rxd_sync_q)) begin
        rx_load      = 1'b1;
        rx_load_data = rx_shift_q[8:1];
        rx_done_set  = 1'b1;
      end
    end
  end

  // Registers; hardware set of a done flag beats a software clear
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q    <= `CTL_RESET;
      pwr_q    <= `PWR_RESET;
      rx_buf_q <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_q <= sfr_wdata_i;
      end
      if (wr_pwr) begin
        pwr_q <= sfr_wdata_i;
      end
      if (rx_load) begin
        rx_buf_q <= rx_load_data;
        if (mode != `MODE_SHIFT) begin
          ctl_q[`CTL_RX_NINTH] <= rx_load_ninth;
        end
      end
      if (tx_done_set) begin
        ctl_q[`CTL_TX_DONE] <= 1'b1;
      end
      if (rx_done_set) begin
        ctl_q[`CTL_RX_DONE] <= 1'b1;
      end
    end
  end

  // Registered outputs: read data, pins, interrupt, queue room
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 8'h00;
      rxd_o       <= 1'b1;
      rxd_oe_o    <= 1'b0;
      txd_o       <= 1'b1;
      irq_o       <= 1'b0;
      txq_ready_o <= 1'b1;
    end else begin
      if (sfr_rd_i) begin
        case (sfr_addr_i)
          `SFR_ADDR_CONTROL: sfr_rdata_o <= ctl_q;
          `SFR_ADDR_BUFFER:  sfr_rdata_o <= rx_buf_q;
          `SFR_ADDR_POWER:   sfr_rdata_o <= pwr_q;
          default:           sfr_rdata_o <= 8'h00;
        endcase
      end
      // Mode 0: txd is the shift clock, low for the first half-bit
      if (m0_busy_q) begin
        txd_o    <= (m0_clk_q >= `SHIFT_CLK_HALF);
        rxd_oe_o <= !m0_is_rx_q;
        rxd_o    <= m0_shift_q[0];
      end else begin
        txd_o    <= (mode == `MODE_SHIFT) ? 1'b1 : tx_shift_q[0];
        rxd_oe_o <= 1'b0;
        rxd_o    <= 1'b1;
      end
      irq_o       <= ctl_q[`CTL_TX_DONE] | ctl_q[`CTL_RX_DONE];
      txq_ready_o <= q_ready;
    end
  end
endmodule // four_mode_serial_port

// file: verilog/serial_port_defs.vh
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Special function register addresses
`define SFR_ADDR_CONTROL  8'h98
`define SFR_ADDR_BUFFER   8'h99
`define SFR_ADDR_POWER    8'h87

// Port control register fields
`define CTL_MODE_HI       7
`define CTL_MODE_LO       6
`define CTL_MULTIPROC     5
`define CTL_RX_ENABLE     4
`define CTL_TX_NINTH      3
`define CTL_RX_NINTH      2
`define CTL_TX_DONE       1
`define CTL_RX_DONE       0
`define CTL_RESET         8'h00

// Power control register fields
`define PWR_BAUD_DOUBLE   7
`define PWR_RESET         8'h00

// Mode encodings
`define MODE_SHIFT        2'h0
`define MODE_ASYNC8       2'h1
`define MODE_FIXED9       2'h2
`define MODE_VAR9         2'h3

// Timing counts in oscillator clocks (shift, prescaler) and in baud ticks (bit phase)
`define SHIFT_BIT_CLKS    4'hc
`define SHIFT_CLK_HALF    4'h6
`define FIXED_TICK_SLOW   2'h3
`define FIXED_TICK_FAST   2'h1
`define TICKS_PER_BIT     4'hf
`define TICK_MID_SAMPLE   4'h7

// Frame lengths in bits
`define FRAME_BITS_8      4'ha
`define FRAME_BITS_9      4'hb
`define RX_SAMPLE_BITS    4'h9
`define SHIFT_DATA_BITS   4'h8

`endif

// file: test/serial_port_checker.sv
`include "serial_port_defs.vh"
module serial_port_checker #(
  parameter TXQ_DEPTH = 32
) (
  input wire       core_clk_i,  // Clock
  input wire       reset_n_i,   // Reset
  input wire [7:0] sfr_addr_i,  // Address
  input wire       sfr_wr_i,    // Write
  input wire       sfr_rd_i,    // Read
  input wire [7:0] sfr_wdata_i, // Wdata
  input wire [7:0] sfr_rdata_o, // Rdata
  input wire       t1_ovf_i,    // Overflow
  input wire       rxd_i,       // Pin in
  input wire       rxd_o,       // Pin out
  input wire       rxd_oe_o,    // Pin enable
  input wire       txd_o,       // Transmit
  input wire       irq_o,       // Interrupt
  input wire       txq_ready_o  // Queue room
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  reg [1:0] mode_q;
  reg       dbl_q;
  reg [9:0] low_q;
  reg [7:0] oe_q;
  // Shadow of mode and rate; run lengths, since bits outlast a repetition
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= 2'h0;
      dbl_q <= 1'b0;
      low_q <= 10'h000;
      oe_q <= 8'h00;
    end else begin
      if (sfr_wr_i && sfr_addr_i == `SFR_ADDR_CONTROL) mode_q <= sfr_wdata_i[7:6];
      if (sfr_wr_i && sfr_addr_i == `SFR_ADDR_POWER) dbl_q <= sfr_wdata_i[`PWR_BAUD_DOUBLE];
      low_q <= txd_o ? 10'h000 : low_q + 10'h001;
      oe_q <= rxd_oe_o ? oe_q + 8'h01 : 8'h00;
    end
  end
  // Shift clock halves
  sequence clk_low_phase;
    !txd_o [*6];
  endsequence
  sequence clk_high_phase;
    txd_o [*6];
  endsequence
  reset_out_a: assert property ($rose(reset_n_i) |-> txd_o && !rxd_oe_o && !irq_o && txq_ready_o)
    else $error("outputs wrong after reset");
  unmapped_read_a: assert property (sfr_rd_i && !(sfr_addr_i inside {`SFR_ADDR_CONTROL, `SFR_ADDR_BUFFER,
    `SFR_ADDR_POWER}) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");
  irq_flags_a: assert property (sfr_rd_i && sfr_addr_i == `SFR_ADDR_CONTROL |=> irq_o == (|sfr_rdata_o[1:0]))
    else $error("interrupt differs from done flags");
  oe_mode0_a: assert property (rxd_oe_o |-> mode_q == `MODE_SHIFT)
    else $error("rxd driven outside mode 0");
  shift_clock_a: assert property (mode_q == `MODE_SHIFT && $fell(txd_o) |-> clk_low_phase ##1 clk_high_phase)
    else $error("shift clock not six low six high");
  oe_length_a: assert property ($fell(rxd_oe_o) |-> oe_q == 8'd96)
    else $error("mode 0 byte not 96 clocks");
  data_steady_a: assert property (rxd_oe_o && $past(rxd_oe_o) && txd_o && $past(txd_o) |-> $stable(rxd_o))
    else $error("mode 0 data moved while clock high");
  bit_width_a: assert property (mode_q == `MODE_FIXED9 && $rose(txd_o) |->
    low_q % (dbl_q ? 10'd32 : 10'd64) == 10'd0)
    else $error("mode 2 bit length wrong");
endmodule // serial_port_checker

bind four_mode_serial_port serial_port_checker #(.TXQ_DEPTH(TXQ_DEPTH)) serial_port_checker_inst (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .t1_ovf_i(t1_ovf_i),
  .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o), .txq_ready_o(txq_ready_o));

// file: test/serial_peer_model.sv
module serial_peer_model (
  input  wire logic       clk_i,  // Bench clock
  input  wire logic       txd_i,  // Device transmit
  input  wire logic       oe_i,   // Device drives rxd
  input  wire logic       pin_i,  // Resolved rxd
  input  wire logic [1:0] mode_i, // Mode spoken
  input  wire logic [7:0] bits_i, // Clocks per bit
  output logic            line_o, // Peer rxd drive
  output logic [9:0]      got_o,  // Last async frame
  output logic [7:0]      m0_o,   // Last mode 0 byte
  output int              cnt_o   // Frames seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] frame;
  // Line idles at the pull-up level
  initial begin
    line_o = 1'b1;
    cnt_o = 0;
  end
  // Async frame to the device, lsb first, ninth only in 9-bit modes
  task automatic send_async(input logic [8:0] d);
    logic [10:0] f;
    f = (mode_i == 2'h1) ? {2'b11, d[7:0], 1'b0} : {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (bits_i) @(posedge clk_i);
    end
    #1;
  endtask
  // Mode 0 source: next bit on each clock fall, released after the last
  task automatic shift_load(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i);
      line_o <= d[i];
    end
    @(posedge txd_i);
    repeat (6) @(posedge clk_i);
    line_o <= 1'b1;
    #1;
  endtask
  // Mode 0 sink samples on the clock rise
  always @(posedge txd_i) begin
    if (oe_i) m0_o <= {pin_i, m0_o[7:1]};
  end
  // Async sink samples mid-bit, ten bits after start
  always begin
    @(negedge txd_i);
    if (mode_i != 2'h0) begin
      repeat (bits_i / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
        repeat (bits_i) @(posedge clk_i);
        frame[i] = txd_i;
      end
      got_o = frame;
      cnt_o++;
    end
  end
endmodule // serial_peer_model

// file: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = 8'h98;
  localparam logic [7:0] BF = 8'h99;
  localparam logic [7:0] PW = 8'h87;
  logic       core_clk_i = 1'b0;
  logic       reset_n_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic       t1_ovf_i;
  logic [7:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] rd_v;
  logic [1:0] pmode;
  logic [7:0] pbits;
  wire  [7:0] sfr_rdata_o;
  wire        rxd_o, rxd_oe_o, txd_o, irq_o, txq_ready_o, peer_line, pin;
  wire  [9:0] got;
  wire  [7:0] m0;
  int         frames;
  int         errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // Shared rxd pin
  assign pin = rxd_oe_o ? rxd_o : peer_line;
  four_mode_serial_port four_mode_serial_port_inst (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .t1_ovf_i(t1_ovf_i),
    .rxd_i(pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o), .txq_ready_o(txq_ready_o));
  serial_peer_model serial_peer_model_inst (
    .clk_i(core_clk_i), .txd_i(txd_o), .oe_i(rxd_oe_o), .pin_i(pin), .mode_i(pmode), .bits_i(pbits),
    .line_o(peer_line), .got_o(got), .m0_o(m0), .cnt_o(frames));
  always #10 core_clk_i = ~core_clk_i;
  // Overflow every 2nd clock gives 64-clock bits, 32 doubled
  always @(posedge core_clk_i) begin
    #1 t1_ovf_i = ~t1_ovf_i;
  end
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles start and end just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge core_clk_i);
    #1 sfr_wr_i = 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge core_clk_i);
    #1 sfr_rd_i = 1'b0;
    rd_v = sfr_rdata_o;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 900; i++) begin
      rd(CT);
      if ((rd_v & m) === m) return;
    end
    chk("flags", {2'b00, m}, {2'b00, rd_v});
  endtask
  task automatic t_reset();
    logic [7:0] a [4];
    a = '{CT, BF, PW, 8'h55};
    chk("queue ready", 10'h001, {9'h000, txq_ready_o});
    wr(8'h55, 8'hff);
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset read", 10'h000, {2'b00, rd_v});
    end
    wr(CT, 8'hb8);
    rd(CT);
    chk("control", 10'h0b8, {2'b00, rd_v});
    wr(CT, 8'h00);
  endtask
  task automatic t_async(input logic [1:0] m, input logic dbl, input logic [8:0] d);
    pmode = m;
    pbits = dbl ? 8'h20 : 8'h40;
    wr(PW, {dbl, 7'h00});
    wr(CT, {m, 2'b01, d[8], 3'b000});
    fork
      serial_peer_model_inst.send_async(~d);
      wr(BF, d[7:0]);
    join
    poll(8'h03);
    chk("rx ninth", {9'h000, (m == 2'h1) | ~d[8]}, {9'h000, rd_v[2]});
    chk("tx frame", (m == 2'h1) ? {2'b11, d[7:0]} : {1'b1, d}, got);
    rd(BF);
    chk("rx byte", {2'b00, ~d[7:0]}, {2'b00, rd_v});
    wr(CT, 8'h00);
  endtask
  task automatic t_overrun();
    pmode = 2'h1;
    wr(CT, 8'h50);
    serial_peer_model_inst.send_async(9'h03c);
    wr(CT, 8'h50);
    fork
      serial_peer_model_inst.send_async(9'h0c3);
      begin
        repeat (150) @(posedge core_clk_i);
        #1 rd(BF);
        chk("mid frame", 10'h03c, {2'b00, rd_v});
      end
    join
    serial_peer_model_inst.send_async(9'h055);
    rd(BF);
    chk("overrun", 10'h0c3, {2'b00, rd_v});
  endtask
  task automatic t_multi();
    pmode = 2'h2;
    wr(CT, 8'h80);
    serial_peer_model_inst.send_async(9'h1e1);
    rd(CT);
    chk("rx disabled", 10'h000, {9'h000, rd_v[0]});
    wr(CT, 8'hb0);
    serial_peer_model_inst.send_async(9'h011);
    rd(CT);
    chk("no rx flag", 10'h000, {9'h000, rd_v[0]});
    serial_peer_model_inst.send_async(9'h1ee);
    rd(BF);
    chk("address", 10'h0ee, {2'b00, rd_v});
    wr(CT, 8'h00);
  endtask
  task automatic t_mode0();
    pmode = 2'h0;
    wr(BF, 8'h96);
    poll(8'h02);
    chk("shift out", 10'h096, {2'b00, m0});
    fork
      serial_peer_model_inst.shift_load(8'h3c);
      wr(CT, 8'h10);
    join
    poll(8'h01);
    rd(BF);
    chk("shift in", 10'h03c, {2'b00, rd_v});
    wr(CT, 8'h00);
  endtask
  // Queue fills until it refuses, then drains to the peer
  task automatic t_fifo();
    int base;
    logic full;
    base = frames;
    full = 1'b0;
    pmode = 2'h2;
    wr(CT, 8'h80);
    for (int i = 0; i < 34; i++) begin
      if (txq_ready_o !== 1'b1) full = 1'b1;
      wr(BF, 8'(i) ^ 8'h5a);
    end
    chk("queue full", 10'h001, {9'h000, full});
    for (int i = 0; i < 15000 && frames < base + 33; i++) @(posedge core_clk_i);
    repeat (800) @(posedge core_clk_i);
    #1;
    chk("frames", 10'(base + 33), 10'(frames));
    chk("last frame", 10'h27a, got);
  endtask
  initial begin
    reset_n_i = 1'b0;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    t1_ovf_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    pmode = 2'h1;
    pbits = 8'h40;
    repeat (3) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    t_reset();
    for (int m = 1; m < 4; m++) begin
      t_async(2'(m), 1'b0, 9'h0a5 ^ 9'(m));
      t_async(2'(m), 1'b1, 9'h15a ^ 9'(m));
    end
    t_overrun();
    t_multi();
    t_mode0();
    t_fifo();
    report_and_stop();
  end
endmodule // tb_top
